// file: pig_regs.svh
// Purpose: register offsets, field positions, reset values and vector table for the interrupt gate
// Assumes: byte-wide register port, 250 MHz core clock
// Notes: status word layout keeps mask in the low byte
`ifndef PIG_REGS_SVH
`define PIG_REGS_SVH

// ==========================================
// register offsets
`define PIG_OFS_MASK 8'h08
`define PIG_OFS_PEND 8'h09
`define PIG_OFS_PSW_LO 8'h10
`define PIG_OFS_PSW_HI 8'h11

// ==========================================
// status word fields
`define PIG_PSW_I_BIT 9
`define PIG_PSW_FLAG_LSB 10
`define PIG_FAST_OUT_BIT 3

// ==========================================
// reset values
`define PIG_MASK_RST 8'h00
`define PIG_PEND_RST 8'h00
`define PIG_PSW_HI_RST 8'h00

// ==========================================
// vector table
`define PIG_VEC_BASE 16'h2000
`define PIG_VEC_SERIAL_LO 16'h200C

`endif

// file: pig_pkg.sv
// Purpose: types for the interrupt gate
// Assumes: eight sources
// Notes: none
package pig_pkg;

  typedef struct packed {
    logic enableService;
    logic disableService;
    logic flagsSave;
    logic flagsRestore;
    logic boundary;
  } pig_instr_t;

  typedef struct packed {
    logic callReq;
    logic [2:0] level;
    logic [15:0] vecAddr;
  } pig_call_t;

  typedef enum logic [1:0] {
    PIG_IDLE = 2'b00,
    PIG_PUSH = 2'b01,
    PIG_LOAD = 2'b10
  } pig_state_t;

endpackage : pig_pkg

// file: pig_prio_enc.sv
// Purpose: fixed priority select over pending and enabled requests
// Assumes: bit 7 highest
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module pig_prio_enc #(
  parameter int NSRC = 8
) (
  input wire logic [NSRC-1:0] req,
  output logic any,
  output logic [$clog2(NSRC)-1:0] level
);
  always_comb begin
    any = 1'b0;
    level = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (req[i]) begin
        any = 1'b1;
        level = i[$clog2(NSRC)-1:0];
      end
    end
  end
endmodule : pig_prio_enc
`default_nettype wire

// file: prioritized_interrupt_gate.sv
// Purpose: interrupt enable, priority select and forced call for the core sequencer
// Assumes: sources and instruction strobes synchronous to ref_clk
// Notes: one call per boundary; sequencer performs the stack push and vector fetch
`timescale 1ns/1ps
`default_nettype none
`include "pig_regs.svh"
module prioritized_interrupt_gate
  import pig_pkg::*;
#(
  parameter int NSRC = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [NSRC-1:0] srcReq,
  input wire pig_instr_t instr,
  input wire logic callDone,
  input wire logic pushDone,
  input wire logic [15:0] popWord,
  input wire logic [15:0] flagsIn,
  input wire logic flagsWe,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  output logic [15:0] statusWord,
  output logic [15:0] pushWord,
  output logic pushReq,
  output logic loadPc,
  output pig_call_t callOut
);

  // ==========================================
  // state
  logic [7:0] mask_ff;
  logic [NSRC-1:0] pend_ff;
  logic [NSRC-1:0] srcPrev_ff;
  logic gie_ff;
  logic [5:0] flags_ff;
  logic lockout_ff;
  pig_state_t state_ff;
  pig_state_t nxt_state;
  logic [2:0] lvl_ff;
  logic [7:0] regRdata_ff;
  logic [15:0] pushWord_ff;

  logic [NSRC-1:0] rise;
  logic [NSRC-1:0] armed;
  logic anyArmed;
  logic [2:0] selLvl;
  logic take;
  logic wrMask;
  logic wrPend;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  assign wrMask = regWr && hit(regAddr, `PIG_OFS_MASK);
  assign wrPend = regWr && hit(regAddr, `PIG_OFS_PEND);

  // ==========================================
  // request detection
  assign rise = srcReq & ~srcPrev_ff;
  assign armed = pend_ff & mask_ff[NSRC-1:0];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      srcPrev_ff <= '0;
    end else begin
      srcPrev_ff <= srcReq;
    end
  end

  pig_prio_enc #(
    .NSRC(NSRC)
  ) u_prio (
    .req(armed),
    .any(anyArmed),
    .level(selLvl)
  );

  // service only at a boundary, globally enabled, not locked out
  assign take = instr.boundary && gie_ff && anyArmed && !lockout_ff &&
                (state_ff == PIG_IDLE) && !instr.flagsSave && !instr.flagsRestore;

  // ==========================================
  // pending register
  // hardware set wins over software clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_ff <= `PIG_PEND_RST;
    end else begin
      for (int i = 0; i < NSRC; i++) begin
        if (rise[i]) begin
          pend_ff[i] <= 1'b1;
        end else if (take && selLvl == i[2:0]) begin
          pend_ff[i] <= 1'b0;
        end else if (wrPend) begin
          pend_ff[i] <= regWdata[i];
        end
      end
    end
  end

  // ==========================================
  // status word: mask, global enable, flags
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_ff <= `PIG_MASK_RST;
    end else if (instr.flagsSave) begin
      mask_ff <= 8'h00;
    end else if (instr.flagsRestore) begin
      mask_ff <= popWord[7:0];
    end else if (flagsWe) begin
      mask_ff <= flagsIn[7:0];
    end else if (wrMask) begin
      mask_ff <= regWdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gie_ff <= 1'b0;
    end else if (instr.flagsSave) begin
      gie_ff <= 1'b0;
    end else if (instr.flagsRestore) begin
      gie_ff <= popWord[`PIG_PSW_I_BIT];
    end else if (instr.enableService) begin
      gie_ff <= 1'b1;
    end else if (instr.disableService) begin
      gie_ff <= 1'b0;
    end else if (flagsWe) begin
      gie_ff <= flagsIn[`PIG_PSW_I_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_ff <= 6'h00;
    end else if (instr.flagsSave) begin
      flags_ff <= 6'h00;
    end else if (instr.flagsRestore) begin
      flags_ff <= popWord[15:`PIG_PSW_FLAG_LSB];
    end else if (flagsWe) begin
      flags_ff <= flagsIn[15:`PIG_PSW_FLAG_LSB];
    end
  end

  assign statusWord = {flags_ff, gie_ff, 1'b0, mask_ff};

  // ==========================================
  // one-boundary lockout after call, save, restore, enable, disable
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lockout_ff <= 1'b0;
    end else if (instr.flagsSave || instr.flagsRestore || instr.enableService ||
                 instr.disableService || callDone) begin
      lockout_ff <= 1'b1;
    end else if (instr.boundary) begin
      lockout_ff <= 1'b0;
    end
  end

  // ==========================================
  // forced call sequence
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      PIG_IDLE: begin
        if (take) begin
          nxt_state = PIG_PUSH;
        end
      end
      PIG_PUSH: begin
        if (pushDone) begin
          nxt_state = PIG_LOAD;
        end
      end
      PIG_LOAD: begin
        if (callDone) begin
          nxt_state = PIG_IDLE;
        end
      end
      default: nxt_state = PIG_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= PIG_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_ff <= 3'h0;
    end else if (take) begin
      lvl_ff <= selLvl;
    end
  end

  // flags save pushes the word as it stood before clearing
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pushWord_ff <= 16'h0000;
    end else if (instr.flagsSave) begin
      pushWord_ff <= statusWord;
    end
  end

  assign pushWord = pushWord_ff;
  assign pushReq = (state_ff == PIG_PUSH);
  assign loadPc = (state_ff == PIG_LOAD);
  // serial (level 6) lands on 200Ch, level 7 on 200Eh
  assign callOut.callReq = (state_ff != PIG_IDLE);
  assign callOut.level = lvl_ff;
  assign callOut.vecAddr = `PIG_VEC_BASE + {12'h000, lvl_ff, 1'b0};

  // ==========================================
  // register read port
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata_ff <= 8'h00;
    end else if (regRd) begin
      unique case (regAddr)
        `PIG_OFS_MASK: regRdata_ff <= mask_ff;
        `PIG_OFS_PEND: regRdata_ff <= pend_ff;
        `PIG_OFS_PSW_LO: regRdata_ff <= statusWord[7:0];
        `PIG_OFS_PSW_HI: regRdata_ff <= statusWord[15:8];
        default: regRdata_ff <= 8'h00;
      endcase
    end else begin
      regRdata_ff <= 8'h00;
    end
  end

  assign regRdata = regRdata_ff;

endmodule : prioritized_interrupt_gate
`default_nettype wire

// file: pig_gate_props.sv
// Purpose: port checks for the interrupt gate
// Assumes: one clock domain
// Notes: bound after the module
`timescale 1ns/1ps
`default_nettype none
module pig_gate_props
  import pig_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire pig_instr_t instr,
  input wire logic callDone,
  input wire logic pushDone,
  input wire logic [15:0] popWord,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic [15:0] statusWord,
  input wire logic [15:0] pushWord,
  input wire logic pushReq,
  input wire logic loadPc,
  input wire pig_call_t callOut
);
  // ==========================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_push; pushReq && pushDone; endsequence
  sequence s_load; loadPc && callDone; endsequence
  chk_push_first: assert property (s_push |=> loadPc && !pushReq)
    else $error("load did not follow push");
  chk_call_end: assert property (s_load |=> !loadPc && !pushReq)
    else $error("call did not end");
  chk_rd_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data outside its cycle");
  chk_mask_wr: assert property (regWr && regAddr == 8'h08 && !instr.flagsSave
    && !instr.flagsRestore |=> statusWord[7:0] == $past(regWdata)) else $error("mask write");
  chk_mask_rd: assert property (regRd && regAddr == 8'h08 |=> regRdata == $past(statusWord[7:0]))
    else $error("mask read");
  chk_save_clr: assert property (instr.flagsSave |=> statusWord == 16'h0000
    && pushWord == $past(statusWord)) else $error("flags save");
  chk_restore_word: assert property (instr.flagsRestore && !instr.flagsSave |=>
    statusWord[15:9] == $past(popWord[15:9]) && statusWord[7:0] == $past(popWord[7:0]))
    else $error("flags restore");
  chk_call_gate: assert property ($rose(pushReq) |-> $past(instr.boundary && statusWord[9])
    && !$past(instr.flagsSave | instr.flagsRestore | instr.enableService)) else $error("gate");
  chk_vec_addr: assert property (callOut.callReq |->
    callOut.vecAddr == 16'h2000 + {12'h000, callOut.level, 1'b0}) else $error("vector");
endmodule : pig_gate_props
bind prioritized_interrupt_gate pig_gate_props u_props (.ref_clk(ref_clk), .rst_n(rst_n),
  .instr(instr), .callDone(callDone), .pushDone(pushDone), .popWord(popWord),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .statusWord(statusWord), .pushWord(pushWord), .pushReq(pushReq), .loadPc(loadPc),
  .callOut(callOut));
`default_nettype wire

// file: pig_seq_model.sv
// Purpose: core sequencer stand-in answering push and load
// Assumes: pushReq and loadPc are levels
// Notes: lat adds wait cycles, a slow stack
`timescale 1ns/1ps
`default_nettype none
module pig_seq_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] lat,
  input wire logic pushReq,
  input wire logic loadPc,
  output var logic pushDone,
  output var logic callDone
);
  logic [3:0] waitCnt;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitCnt <= 4'h0;
      pushDone <= 1'b0;
      callDone <= 1'b0;
    end else begin
      pushDone <= 1'b0;
      callDone <= 1'b0;
      // one done pulse per step, push before load
      if ((pushReq || loadPc) && !pushDone && !callDone) begin
        if (waitCnt >= lat) begin
          waitCnt <= 4'h0;
          pushDone <= pushReq;
          callDone <= loadPc;
        end else begin
          waitCnt <= waitCnt + 4'h1;
        end
      end
    end
  end
endmodule : pig_seq_model
`default_nettype wire

// file: tb.sv
// Purpose: directed run of the interrupt gate
// Assumes: flags port unused
// Notes: instructions are single pulses
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pig_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] srcReq = 8'h00;
  pig_instr_t instr = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [15:0] popWord = 16'h0000;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic [3:0] lat = 4'h0;
  logic [7:0] regRdata, rd;
  logic [15:0] statusWord, pushWord;
  logic pushReq, loadPc, pushDone, callDone;
  pig_call_t callOut;
  int error_cnt = 0;
  int check_count = 0;
  always #2 ref_clk = ~ref_clk;
  prioritized_interrupt_gate dut (.ref_clk(ref_clk), .rst_n(rst_n), .srcReq(srcReq),
    .instr(instr), .callDone(callDone), .pushDone(pushDone), .popWord(popWord),
    .flagsIn(16'h0000), .flagsWe(1'b0), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .statusWord(statusWord),
    .pushWord(pushWord), .pushReq(pushReq), .loadPc(loadPc), .callOut(callOut));
  pig_seq_model seq (.ref_clk(ref_clk), .rst_n(rst_n), .lat(lat), .pushReq(pushReq),
    .loadPc(loadPc), .pushDone(pushDone), .callDone(callDone));
  // ==========================================
  // tasks
  task wrap_up;
    if (error_cnt == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task cmp(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : cmp
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wr
  task rdb(input logic [7:0] a);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 rd = regRdata;
  endtask : rdb
  task pulse(input pig_instr_t v);
    @(posedge ref_clk);
    instr <= v;
    @(posedge ref_clk);
    instr <= '0;
    #1;
  endtask : pulse
  task bnd(input logic e);
    pulse(5'h01);
    cmp(pushReq, e);
  endtask : bnd
  // bounded wait for the forced call to finish
  task endcall;
    int n;
    n = 0;
    while ((pushReq !== 1'b0 || loadPc !== 1'b0) && n < 40) begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (n >= 40) begin
      error_cnt++;
      wrap_up;
    end
  endtask : endcall
  // ==========================================
  // sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdb(8'h08); cmp(rd, 8'h00);
    rdb(8'h09); cmp(rd, 8'h00);
    cmp(statusWord, 16'h0000);
    rdb(8'h3C); cmp(rd, 8'h00);
    @(posedge ref_clk);
    srcReq <= 8'h48;
    rdb(8'h09); cmp(rd, 8'h48);
    bnd(1'b0);
    wr(8'h08, 8'hFF);
    rdb(8'h08); cmp(rd, 8'hFF);
    cmp(statusWord[7:0], 8'hFF);
    pulse(5'h10); cmp(statusWord[9], 1'b1);
    bnd(1'b0);
    bnd(1'b1);
    cmp(callOut.level, 3'h6);
    cmp(callOut.vecAddr, 16'h200C);
    endcall;
    rdb(8'h09); cmp(rd, 8'h08);
    bnd(1'b0);
    lat <= 4'h3;
    bnd(1'b1);
    cmp(callOut.vecAddr, 16'h2006);
    endcall;
    bnd(1'b0);
    srcReq <= 8'h49;
    wr(8'h08, 8'hFE);
    bnd(1'b0);
    pulse(5'h04); cmp(pushWord, 16'h02FE);
    cmp(statusWord, 16'h0000);
    wr(8'h08, 8'h01);
    bnd(1'b0);
    popWord <= 16'h02FF;
    pulse(5'h02); cmp(statusWord, 16'h02FF);
    bnd(1'b0);
    bnd(1'b1);
    cmp(callOut.vecAddr, 16'h2000);
    endcall;
    pulse(5'h08); cmp(statusWord[9], 1'b0);
    wr(8'h09, 8'h82);
    rdb(8'h09); cmp(rd, 8'h82);
    wr(8'h09, 8'h00);
    rdb(8'h09); cmp(rd, 8'h00);
    wrap_up;
  end
endmodule : tb
`default_nettype wire
